// ===== atc_pkg.sv
// Shared constants and types for the auxiliary auto-reload timer
package atc_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [7:0] ATC_ADDR_CONTROL    = 8'h91;
    localparam logic [7:0] ATC_ADDR_RELOAD_LOW = 8'h92;
    localparam logic [7:0] ATC_ADDR_IRQ_STATUS = 8'h98;
    localparam logic [7:0] ATC_ADDR_IRQ_MASK   = 8'h99;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [7:0] ATC_RST_CONTROL     = 8'h00;
    localparam logic [7:0] ATC_RST_RELOAD_LOW  = 8'h00;
    localparam logic [2:0] ATC_RST_IRQ         = 3'h0;
    localparam logic [7:0] ATC_RDATA_UNMAPPED  = 8'h00;

    // ********************************************************************
    // Control register field positions
    // ********************************************************************
    localparam int ATC_BIT_HIGH_OVF   = 7;
    localparam int ATC_BIT_LOW_OVF    = 6;
    localparam int ATC_BIT_LOW_IRQ_EN = 5;
    localparam int ATC_BIT_CAPTURE_EN = 4;
    localparam int ATC_BIT_SPLIT      = 3;
    localparam int ATC_BIT_RUN        = 2;

    // Interrupt status and mask bit positions
    localparam int ATC_IRQ_HIGH_OVF = 0;
    localparam int ATC_IRQ_LOW_OVF  = 1;
    localparam int ATC_IRQ_CAPTURE  = 2;

    // ********************************************************************
    // Source select codes and timing
    // ********************************************************************
    localparam logic [1:0] ATC_SRC_RTC_ALT   = 2'b11;
    localparam logic [3:0] ATC_DIV12_LAST    = 4'd11;
    localparam logic [2:0] ATC_DIV8_LAST     = 3'd7;
    localparam logic [7:0] ATC_BYTE_MAX      = 8'hff;
    localparam logic [7:0] ATC_BYTE_ZERO     = 8'h00;

    // Control register as fields
    typedef struct packed {
        logic       high_overflow_flag;
        logic       low_overflow_flag;
        logic       low_byte_irq_enable;
        logic       osc_capture_enable;
        logic       split_mode_select;
        logic       run_control;
        logic [1:0] alt_source_select;
    } atc_control_t;

    // Plain register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } atc_bus_req_t;

endpackage

// ===== atc_timer.sv
// Auxiliary 16-bit / dual 8-bit auto-reload timer with control and reload-low registers
//
// Contract
// - High overflow flag sets when the upper byte wraps 0xFF to 0x00; in 16-bit capture mode the code sets it on triggers only.
// - In 16-bit mode high flag sets when count wraps 0xFFFF to 0x0000; with capture enabled the code does not set it on that wrap.
// - With timer interrupt enabled, high flag setting raises an interrupt request.
// - Hardware never clears either overflow flag; software writes zero.
// - Low overflow flag sets on lower byte wrap, in both modes.
// - Low-byte enable plus timer enable also interrupts on lower byte wrap.
// - Capture enable one selects oscillator-period capture; zero is plain timer.
// - Split bit zero gives one 16-bit counter; one gives two 8-bit counters.
// - Counting only while run bit is one; in 16-bit mode it halts all.
// - In split mode run gates upper byte only; lower byte always runs.
// - Source select picks alternate clock and capture trigger per two-bit code.
// - Split mode: alternate clock shared; per-byte select picks alternate or core clock.
// - Alternate sources are synchronised to the core clock before use.
// - Reload-low register holds low reload byte, read/write, resets to zero.
// - In 16-bit mode reload value loads on each 0xFFFF wrap; with capture enabled the code wraps to 0x0000 without a reload.
// - In split mode each byte reloads from its own reload byte.
// - In capture mode a trigger copies count to reload and sets high flag.
// - Split mode with low enable interrupts on either byte overflow.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module atc_timer (
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    input  wire atc_pkg::atc_bus_req_t bus_req,
    output logic [7:0]                 rdata,
    input  wire logic                  rtc_osc_in,
    input  wire logic                  ext_osc_in,
    input  wire logic                  high_byte_clock_select,
    input  wire logic                  low_byte_clock_select,
    input  wire logic [7:0]            aux_timer_reload_high,
    output logic [15:0]                count,
    output logic                       reload_high_load,
    output logic [7:0]                 reload_high_value,
    output logic                       irq
);
    import atc_pkg::*;

    // ********************************************************************
    // Helpers
    // ********************************************************************

    // True when a byte is at 0xFF, about to wrap or reload
    function automatic logic byte_full(input logic [7:0] b);
        byte_full = (b == ATC_BYTE_MAX);
    endfunction

    // Next byte value: reload on wrap, else increment
    function automatic logic [7:0] byte_next(input logic [7:0] b,
                                             input logic [7:0] rl);
        if (byte_full(b)) begin
            byte_next = rl;
        end else begin
            byte_next = b + 8'h01;
        end
    endfunction

    // ********************************************************************
    // State
    // ********************************************************************
    atc_control_t ctrl_q;
    logic [7:0]   reload_low_q;
    logic [7:0]   cnt_low_q;
    logic [7:0]   cnt_high_q;
    logic [2:0]   irq_status_q;
    logic [2:0]   irq_mask_q;
    logic [7:0]   rdata_q;
    logic         irq_q;
    logic         rl_high_load_q;
    logic [7:0]   rl_high_value_q;

    logic [3:0]   div12_q;
    logic         div12_tick_q;
    logic [2:0]   rtc_sync_q;
    logic [2:0]   ext_sync_q;
    logic [2:0]   div8_q;
    logic         rtc_tick;
    logic         ext_edge;
    logic         ext8_tick;

    // Decoded controls
    logic         alt_tick;
    logic         trig_tick;
    logic         tick_low;
    logic         tick_high;
    logic         wr_ctrl;
    logic         wr_rl_low;
    logic         wr_mask;
    logic         rd_status;

    // Overflow and capture events of this cycle
    logic         ev_low_wrap;
    logic         ev_high_wrap;
    logic         ev_capture;

    // ********************************************************************
    // Register decode
    // ********************************************************************

    // One strobe at a time; the slave never stalls the master
    assign wr_ctrl   = bus_req.wr && (bus_req.addr == ATC_ADDR_CONTROL);
    assign wr_rl_low = bus_req.wr && (bus_req.addr == ATC_ADDR_RELOAD_LOW);
    assign wr_mask   = bus_req.wr && (bus_req.addr == ATC_ADDR_IRQ_MASK);
    assign rd_status = bus_req.rd && (bus_req.addr == ATC_ADDR_IRQ_STATUS);

    // ********************************************************************
    // Alternate clock sources
    // ********************************************************************

    // Core clock divided by twelve as a one-cycle enable
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div12_q      <= 4'd0;
            div12_tick_q <= 1'b0;
        end else if (div12_q == ATC_DIV12_LAST) begin
            div12_q      <= 4'd0;
            div12_tick_q <= 1'b1;
        end else begin
            div12_q      <= div12_q + 4'd1;
            div12_tick_q <= 1'b0;
        end
    end

    // Oscillator inputs through two flops; third flop only for edge finding
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rtc_sync_q <= 3'b000;
            ext_sync_q <= 3'b000;
        end else begin
            rtc_sync_q <= {rtc_sync_q[1:0], rtc_osc_in};
            ext_sync_q <= {ext_sync_q[1:0], ext_osc_in};
        end
    end

    // Edges seen only after the second stage, never the first
    assign rtc_tick = rtc_sync_q[1] && !rtc_sync_q[2];
    assign ext_edge = ext_sync_q[1] && !ext_sync_q[2];

    // External oscillator divided by eight, counted in rising edges
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div8_q <= 3'd0;
        end else if (ext_edge) begin
            div8_q <= div8_q + 3'd1;
        end
    end

    assign ext8_tick = ext_edge && (div8_q == ATC_DIV8_LAST);

    // Source select: codes 00..10 give core/12, 11 the real-time oscillator
    always_comb begin
        if (ctrl_q.alt_source_select == ATC_SRC_RTC_ALT) begin
            alt_tick = rtc_tick;
        end else begin
            alt_tick = div12_tick_q;
        end
        // Upper select bit picks the capture trigger
        if (ctrl_q.alt_source_select[1]) begin
            trig_tick = ext8_tick;
        end else begin
            trig_tick = rtc_tick;
        end
    end

    // Per-byte choice between core clock and the shared alternate clock
    assign tick_low  = low_byte_clock_select  ? 1'b1 : alt_tick;
    assign tick_high = high_byte_clock_select ? 1'b1 : alt_tick;

    // ********************************************************************
    // Counter
    // ********************************************************************

    // Wrap and capture events; 16-bit mode follows the low-byte select
    always_comb begin
        ev_low_wrap  = 1'b0;
        ev_high_wrap = 1'b0;
        ev_capture   = 1'b0;
        if (ctrl_q.split_mode_select) begin
            // Lower byte ignores run control in split mode
            ev_low_wrap  = tick_low && byte_full(cnt_low_q);
            ev_high_wrap = ctrl_q.run_control && tick_high
                           && byte_full(cnt_high_q);
        end else if (ctrl_q.run_control && tick_low) begin
            ev_low_wrap  = byte_full(cnt_low_q);
            ev_high_wrap = byte_full(cnt_low_q) && byte_full(cnt_high_q)
                           && !ctrl_q.osc_capture_enable;
        end
        if (ctrl_q.osc_capture_enable && !ctrl_q.split_mode_select) begin
            ev_capture = trig_tick;
        end
    end

    // Counting bytes; split mode treats them as two timers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_low_q  <= ATC_BYTE_ZERO;
            cnt_high_q <= ATC_BYTE_ZERO;
        end else if (ctrl_q.split_mode_select) begin
            if (tick_low) begin
                cnt_low_q <= byte_next(cnt_low_q, reload_low_q);
            end
            if (ctrl_q.run_control && tick_high) begin
                cnt_high_q <= byte_next(cnt_high_q, aux_timer_reload_high);
            end
        end else if (ctrl_q.run_control && tick_low) begin
            if (ctrl_q.osc_capture_enable) begin
                // Free wrap: reload registers hold captures, not a period
                {cnt_high_q, cnt_low_q} <= {cnt_high_q, cnt_low_q} + 16'h0001;
            end else if (byte_full(cnt_low_q) && byte_full(cnt_high_q)) begin
                cnt_low_q  <= reload_low_q;
                cnt_high_q <= aux_timer_reload_high;
            end else begin
                {cnt_high_q, cnt_low_q} <= {cnt_high_q, cnt_low_q} + 16'h0001;
            end
        end
    end

    // ********************************************************************
    // Control register
    // ********************************************************************

    // Flags: hardware only sets; a same-cycle set beats a software clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= ATC_RST_CONTROL;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= bus_req.wdata;
            end
            if (ev_high_wrap || ev_capture) begin
                ctrl_q.high_overflow_flag <= 1'b1;
            end
            if (ev_low_wrap) begin
                ctrl_q.low_overflow_flag <= 1'b1;
            end
        end
    end

    // Reload-low: software writes, captures overwrite
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reload_low_q <= ATC_RST_RELOAD_LOW;
        end else if (ev_capture) begin
            reload_low_q <= cnt_low_q;
        end else if (wr_rl_low) begin
            reload_low_q <= bus_req.wdata;
        end
    end

    // Capture of the upper byte goes to the reload-high holder outside
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rl_high_load_q  <= 1'b0;
            rl_high_value_q <= ATC_BYTE_ZERO;
        end else begin
            rl_high_load_q <= ev_capture;
            if (ev_capture) begin
                rl_high_value_q <= cnt_high_q;
            end
        end
    end

    // ********************************************************************
    // Interrupts
    // ********************************************************************

    // Sticky event bits, cleared by reading; a new event wins the read
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_status_q <= ATC_RST_IRQ;
        end else begin
            if (rd_status) begin
                irq_status_q <= ATC_RST_IRQ;
            end
            if (ev_high_wrap) begin
                irq_status_q[ATC_IRQ_HIGH_OVF] <= 1'b1;
            end
            if (ev_low_wrap) begin
                irq_status_q[ATC_IRQ_LOW_OVF] <= 1'b1;
            end
            if (ev_capture) begin
                irq_status_q[ATC_IRQ_CAPTURE] <= 1'b1;
            end
        end
    end

    // Mask bits act as the timer interrupt enable per event
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_q <= ATC_RST_IRQ;
        end else if (wr_mask) begin
            irq_mask_q <= bus_req.wdata[2:0];
        end
    end

    // Level request; low-byte events need the low enable too, in any mode
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (irq_status_q[ATC_IRQ_HIGH_OVF] && irq_mask_q[ATC_IRQ_HIGH_OVF])
                  || (irq_status_q[ATC_IRQ_CAPTURE] && irq_mask_q[ATC_IRQ_CAPTURE])
                  || (irq_status_q[ATC_IRQ_LOW_OVF] && irq_mask_q[ATC_IRQ_LOW_OVF]
                      && ctrl_q.low_byte_irq_enable);
        end
    end

    // ********************************************************************
    // Read data
    // ********************************************************************

    // Answer one cycle after the read strobe; unmapped reads give zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= ATC_RDATA_UNMAPPED;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                ATC_ADDR_CONTROL:    rdata_q <= ctrl_q;
                ATC_ADDR_RELOAD_LOW: rdata_q <= reload_low_q;
                ATC_ADDR_IRQ_STATUS: rdata_q <= {5'h00, irq_status_q};
                ATC_ADDR_IRQ_MASK:   rdata_q <= {5'h00, irq_mask_q};
                default:             rdata_q <= ATC_RDATA_UNMAPPED;
            endcase
        end else begin
            rdata_q <= ATC_RDATA_UNMAPPED;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign rdata             = rdata_q;
    assign irq               = irq_q;
    assign count             = {cnt_high_q, cnt_low_q};
    assign reload_high_load  = rl_high_load_q;
    assign reload_high_value = rl_high_value_q;

endmodule

`default_nettype wire

// ===== atc_timer_assertions.sv
// Concurrent checks on the ports of the auxiliary auto-reload timer
`timescale 1ns/1ps
`default_nettype none

module atc_timer_assertions
    import atc_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          arst_n,
    input  wire atc_bus_req_t  bus_req,
    input  wire logic [7:0]    rdata,
    input  wire logic [15:0]   count,
    input  wire logic [7:0]    aux_timer_reload_high,
    input  wire logic          reload_high_load,
    input  wire logic          irq
);
    logic [7:0]  ctrl_q;
    logic [2:0]  mask_q;
    logic [15:0] cnt_q;
    logic [7:0]  rh_q;

    // ********************************************************************
    // Shadows of software-only bits and last count
    // ********************************************************************
    // Flags are left out of use: hardware may set them behind our back
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= 8'h00;
            mask_q <= 3'h0;
        end else if (bus_req.wr && bus_req.addr == ATC_ADDR_CONTROL) begin
            ctrl_q <= bus_req.wdata;
        end else if (bus_req.wr && bus_req.addr == ATC_ADDR_IRQ_MASK) begin
            mask_q <= bus_req.wdata[2:0];
        end
    end

    // Previous count and reload high byte
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 16'h0000;
            rh_q  <= 8'h00;
        end else begin
            cnt_q <= count;
            rh_q  <= aux_timer_reload_high;
        end
    end

    // ********************************************************************
    // Properties
    // ********************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence ctrl_read_s;
        bus_req.rd && bus_req.addr == ATC_ADDR_CONTROL;
    endsequence

    sequence mask_off_s;
        mask_q == 3'h0 ##1 mask_q == 3'h0;
    endsequence

    reset_clear_a: assert property ($past(!arst_n) |-> count == 16'h0000 && !irq)
        else $error("outputs not cleared after reset");
    read_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
        else $error("read data outside read cycle");
    ctrl_readback_a: assert property (ctrl_read_s |=> rdata[5:0] == ctrl_q[5:0])
        else $error("control bits read back wrong");
    low_step_a: assert property (count[7:0] != cnt_q[7:0] |->
        count[7:0] == cnt_q[7:0] + 8'h01 || cnt_q[7:0] == 8'hff)
        else $error("low byte jumped");
    high_step_a: assert property (count[15:8] != cnt_q[15:8] |->
        count[15:8] == cnt_q[15:8] + 8'h01 || (cnt_q[15:8] == 8'hff &&
        (count[15:8] == rh_q || count[15:8] == 8'h00)))
        else $error("high byte jumped");
    load_pulse_a: assert property (reload_high_load |=> !reload_high_load)
        else $error("reload load pulse too long");
    irq_fall_a: assert property ($fell(irq) |-> $past(bus_req.wr) || $past(bus_req.rd) ||
        $past(bus_req.wr, 2) || $past(bus_req.rd, 2))
        else $error("interrupt dropped without software");
    irq_masked_a: assert property (mask_off_s |=> !irq)
        else $error("interrupt while fully masked");
    low_gate_a: assert property (mask_q == 3'b010 && !ctrl_q[5] ##1
        mask_q == 3'b010 && !ctrl_q[5] |=> !irq)
        else $error("low byte interrupt without enable");
endmodule

bind atc_timer atc_timer_assertions atc_timer_assertions_inst (
    .clk_sys               (clk_sys),
    .arst_n                (arst_n),
    .bus_req               (bus_req),
    .rdata                 (rdata),
    .count                 (count),
    .aux_timer_reload_high (aux_timer_reload_high),
    .reload_high_load      (reload_high_load),
    .irq                   (irq)
);

`default_nettype wire

// ===== aux_timer_control_reload_bench.sv
// Self-checking bench for the auxiliary auto-reload timer
`timescale 1ns/1ps
`default_nettype none

module aux_timer_control_reload_bench;
    import atc_pkg::*;

    // ********************************************************************
    // Stimulus and observed signals
    // ********************************************************************
    logic          clk_sys   = 1'b0;
    logic          arst_n    = 1'b0;
    atc_bus_req_t  bus_req   = '0;
    logic          rtc_osc_in = 1'b0;
    logic          ext_osc_in = 1'b0;
    logic          high_sel  = 1'b0;
    logic          low_sel   = 1'b1;
    logic [7:0]    rh_in     = 8'hff;
    logic [7:0]    rdata;
    logic [15:0]   count;
    logic          hl_load;
    logic [7:0]    hl_value;
    logic          irq;
    logic [15:0]   exp_q[$];
    logic [31:0]   lfsr      = 32'd81894;
    logic [15:0]   c0;
    logic [7:0]    rl;
    logic [7:0]    hv_seen;
    logic          rd_seen   = 1'b0;
    int            err_count = 0;
    int            compares  = 0;
    int            pulses;
    int            n;

    always #20 clk_sys = ~clk_sys;

    atc_timer atc_timer_inst (
        .clk_sys                (clk_sys),
        .arst_n                 (arst_n),
        .bus_req                (bus_req),
        .rdata                  (rdata),
        .rtc_osc_in             (rtc_osc_in),
        .ext_osc_in             (ext_osc_in),
        .high_byte_clock_select (high_sel),
        .low_byte_clock_select  (low_sel),
        .aux_timer_reload_high  (rh_in),
        .count                  (count),
        .reload_high_load       (hl_load),
        .reload_high_value      (hl_value),
        .irq                    (irq)
    );

    // ********************************************************************
    // Tasks
    // ********************************************************************
    task automatic summarize();
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [7:0] got, input logic [15:0] e);
        compares++;
        if ((got & e[15:8]) !== (e[7:0] & e[15:8])) begin
            err_count++;
            $display("mismatch at %0t: read %h expected %h", $time, got, e[7:0]);
        end
    endtask

    task automatic chk_port(input logic [15:0] got, input logic [15:0] e);
        compares++;
        if (got !== e) begin
            err_count++;
            $display("mismatch at %0t: port %h expected %h", $time, got, e);
        end
    endtask

    // Each access is followed by an idle cycle, so no strobe is set twice
    task automatic bus_op(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clk_sys);
        bus_req <= '{a, d, w, !w};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({m, e});
        bus_op(a, 8'h00, 1'b0);
    endtask

    task automatic osc_edges(input logic ext, input int k);
        repeat (k) begin
            repeat (4) @(posedge clk_sys);
            if (ext) ext_osc_in <= 1'b1; else rtc_osc_in <= 1'b1;
            repeat (4) @(posedge clk_sys);
            if (ext) ext_osc_in <= 1'b0; else rtc_osc_in <= 1'b0;
        end
    endtask

    task automatic wait_irq();
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    // 16-bit count model: one step per tick, reload on full wrap
    function automatic logic [15:0] step16(input logic [15:0] c, input int k);
        logic [15:0] e;
        e = c;
        for (int i = 0; i < k; i++) e = (e == 16'hffff) ? {rh_in, rl} : e + 16'h0001;
        return e;
    endfunction

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // ********************************************************************
    // Monitors
    // ********************************************************************
    // Read data stand only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rd_seen) chk_rd(rdata, exp_q.pop_front());
        rd_seen <= bus_req.rd;
    end

    // Capture pulses and the high byte they carry
    always @(negedge clk_sys) begin
        if (hl_load === 1'b1) begin
            pulses++;
            hv_seen = hl_value;
        end
    end

    // Cut a hang well past the longest expected run
    initial begin
        #4000000;
        err_count++;
        summarize();
    end

    // ********************************************************************
    // Main sequence
    // ********************************************************************
    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        lfsr = lfsr_next(lfsr);
        rl = lfsr[7:0] & 8'h7f;
        rd_reg(ATC_ADDR_CONTROL, ATC_RST_CONTROL, 8'hff);
        rd_reg(ATC_ADDR_RELOAD_LOW, ATC_RST_RELOAD_LOW, 8'hff);
        bus_op(8'h97, 8'h5a, 1'b1);
        rd_reg(8'h97, ATC_RDATA_UNMAPPED, 8'hff);
        bus_op(ATC_ADDR_RELOAD_LOW, rl, 1'b1);
        rd_reg(ATC_ADDR_RELOAD_LOW, rl, 8'hff);
        bus_op(ATC_ADDR_CONTROL, 8'h04, 1'b1);
        n = 0;
        while (count !== 16'hffff && n < 70000) begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        chk_port(count, {8'hff, rl});
        rd_reg(ATC_ADDR_CONTROL, 8'hc4, 8'hff);
        rd_reg(ATC_ADDR_IRQ_STATUS, 8'h03, 8'h03);
        chk_port(irq, 1'b0);
        bus_op(ATC_ADDR_CONTROL, 8'hc0, 1'b1);
        @(negedge clk_sys);
        c0 = count;
        repeat (20) @(negedge clk_sys);
        chk_port(count, c0);
        rd_reg(ATC_ADDR_CONTROL, 8'hc0, 8'hff);
        bus_op(ATC_ADDR_CONTROL, 8'h00, 1'b1);
        rd_reg(ATC_ADDR_CONTROL, 8'h00, 8'hff);
        // Split mode, low byte free-running without run
        rd_reg(ATC_ADDR_IRQ_STATUS, 8'h00, 8'h00);
        bus_op(ATC_ADDR_IRQ_MASK, 8'h02, 1'b1);
        bus_op(ATC_ADDR_CONTROL, 8'h28, 1'b1);
        wait_irq();
        chk_port(irq, 1'b1);
        chk_port(count[15:8], c0[15:8]);
        rd_reg(ATC_ADDR_IRQ_STATUS, 8'h02, 8'h03);
        bus_op(ATC_ADDR_CONTROL, 8'h08, 1'b1);
        rd_reg(ATC_ADDR_IRQ_STATUS, 8'h00, 8'h00);
        repeat (300) @(negedge clk_sys);
        chk_port(irq, 1'b0);
        // Split mode, upper byte on core clock
        @(posedge clk_sys);
        rh_in <= lfsr[15:8] & 8'h7f;
        high_sel <= 1'b1;
        low_sel <= 1'b0;
        bus_op(ATC_ADDR_IRQ_MASK, 8'h01, 1'b1);
        rd_reg(ATC_ADDR_IRQ_STATUS, 8'h00, 8'h00);
        bus_op(ATC_ADDR_CONTROL, 8'h0c, 1'b1);
        wait_irq();
        chk_port(irq, 1'b1);
        rd_reg(ATC_ADDR_CONTROL, 8'h80, 8'h80);
        bus_op(ATC_ADDR_IRQ_MASK, 8'h00, 1'b1);
        bus_op(ATC_ADDR_CONTROL, 8'h00, 1'b1);
        rd_reg(ATC_ADDR_IRQ_STATUS, 8'h00, 8'h00);
        // Capture on each trigger source, counter frozen
        low_sel <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            bus_op(ATC_ADDR_CONTROL, 8'h10 | 8'(s), 1'b1);
            @(negedge clk_sys);
            c0 = count;
            pulses = 0;
            osc_edges(s[1], s[1] ? 8 : 1);
            repeat (8) @(negedge clk_sys);
            chk_port(16'(pulses), 16'h0001);
            chk_port(hv_seen, c0[15:8]);
            rd_reg(ATC_ADDR_RELOAD_LOW, c0[7:0], 8'hff);
            rd_reg(ATC_ADDR_IRQ_STATUS, 8'h04, 8'h04);
            rd_reg(ATC_ADDR_CONTROL, 8'h80, 8'h80);
        end
        rl = c0[7:0];
        bus_op(ATC_ADDR_CONTROL, 8'h00, 1'b1);
        pulses = 0;
        osc_edges(1'b0, 1);
        chk_port(16'(pulses), 16'h0000);
        // Alternate clocks: core divided by twelve, then oscillator edges
        low_sel <= 1'b0;
        bus_op(ATC_ADDR_CONTROL, 8'h04, 1'b1);
        @(negedge clk_sys);
        c0 = count;
        repeat (120) @(negedge clk_sys);
        chk_port(count, step16(c0, 10));
        bus_op(ATC_ADDR_CONTROL, 8'h07, 1'b1);
        repeat (2) @(negedge clk_sys);
        c0 = count;
        osc_edges(1'b0, 5);
        repeat (6) @(negedge clk_sys);
        chk_port(count, step16(c0, 5));
        summarize();
    end
endmodule

`default_nettype wire
